// ===== pkg/apr_pkg.sv
package apr_pkg;
  // ==========================================================
  // Bus widths
  // ==========================================================
  localparam int AW = 8;
  localparam int DW = 8;
  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] ADDR_SEC_PIN = 8'h1F;
  localparam logic [7:0] ADDR_SRC = 8'h20;
  localparam logic [7:0] ADDR_ROUTE = 8'h21;
  localparam logic [7:0] ADDR_MISC = 8'h22;
  localparam logic [7:0] ADDR_RSVD = 8'h23;
  localparam logic [7:0] ADDR_REC = 8'h24;
  localparam logic [7:0] ADDR_PLAY_PWR = 8'h25;
  localparam logic [7:0] ADDR_PLAY_GAIN = 8'h26;
  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int SRC_BCLK_BIT = 3;
  localparam int SRC_WCLK_BIT = 2;
  localparam int SRC_RECW_BIT = 1;
  localparam int SRC_DIN_BIT = 0;
  localparam int RT_BCLK_BIT = 7;
  localparam int RT_SBCLK_BIT = 6;
  localparam int RT_WCLK_LSB = 4;
  localparam int RT_SWCLK_LSB = 2;
  localparam int RT_DOUT_BIT = 1;
  localparam int RT_SDOUT_BIT = 0;
  localparam int MISC_GC_BIT = 5;
  localparam int SEC_PIN_LSB = 5;
  // ==========================================================
  // Reset values and word clock codes
  // ==========================================================
  localparam logic [3:0] RST_SRC = 4'h0;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [1:0] RST_SEC_PIN = 2'h0;
  localparam logic [1:0] WSEL_A = 2'h0;
  localparam logic [1:0] WSEL_B = 2'h1;
  localparam logic [1:0] WSEL_C = 2'h2;
endpackage

// ===== pkg/apr_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none
// Control fields and routed nets between register bank and router
interface apr_ctl_if;
  logic [3:0] src;
  logic [7:0] route;
  logic [1:0] sec_pin;
  logic [3:0] sbclk_pins;
  logic bclk_pin, bclk_gen, wclk_pin, wclk_sec, wclk_rsec;
  logic play_fs, rec_fs, din_pin, din_sec, ser_out;
  logic bclk_port, wclk_port, wclk_rec, din_port;
  logic bclk_out, sbclk_out, wclk_out, swclk_out, dout, sdout;
  // Register side drives fields and raw pins
  modport regs (output src, route, sec_pin, sbclk_pins, bclk_pin,
    bclk_gen, wclk_pin, wclk_sec, wclk_rsec, play_fs, rec_fs,
    din_pin, din_sec, ser_out, input bclk_port, wclk_port,
    wclk_rec, din_port, bclk_out, sbclk_out, wclk_out, swclk_out,
    dout, sdout);
  // Router side makes the muxed nets
  modport rtr (input src, route, sec_pin, sbclk_pins, bclk_pin,
    bclk_gen, wclk_pin, wclk_sec, wclk_rsec, play_fs, rec_fs,
    din_pin, din_sec, ser_out, output bclk_port, wclk_port,
    wclk_rec, din_port, bclk_out, sbclk_out, wclk_out, swclk_out,
    dout, sdout);
endinterface
`default_nettype wire

// ===== design/apr_sticky.sv
`timescale 1ns/100ps
`default_nettype none
module apr_sticky #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_flag
);
  // ==========================================================
  // Per-bit sticky flags
  // ==========================================================
  for (genvar g = 0; g < W; g++) begin : g_flag
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        o_flag[g] <= 1'b0;
      end else begin
        o_flag[g] <= i_set[g] | (o_flag[g] & ~i_clr[g]);
      end
    end
  end
endmodule // apr_sticky
`default_nettype wire

// ===== design/apr_route.sv
`timescale 1ns/100ps
`default_nettype none
module apr_route (
  input wire logic i_clk,
  input wire logic i_rst,
  apr_ctl_if.rtr ctl
);
  import apr_pkg::*;
  // ==========================================================
  // Serial port input selection, one clock of latency
  // ==========================================================
  logic sbclk; // Secondary bit clock from chosen pin
  assign sbclk = ctl.sbclk_pins[ctl.sec_pin];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl.bclk_port <= 1'b0;
      ctl.wclk_port <= 1'b0;
      ctl.wclk_rec <= 1'b0;
      ctl.din_port <= 1'b0;
    end else begin
      ctl.bclk_port <= ctl.src[SRC_BCLK_BIT] ? sbclk : ctl.bclk_pin;
      ctl.wclk_port <= ctl.src[SRC_WCLK_BIT] ? ctl.wclk_sec
                                              : ctl.wclk_pin;
      ctl.wclk_rec <= ctl.src[SRC_RECW_BIT] ? ctl.wclk_rsec
                                             : ctl.play_fs;
      ctl.din_port <= ctl.src[SRC_DIN_BIT] ? ctl.din_sec : ctl.din_pin;
    end
  end
  // ==========================================================
  // Output pin selection; reserved codes park the pin low
  // ==========================================================
  logic wclk_d, swclk_d;
  always_comb begin
    case (ctl.route[RT_WCLK_LSB +: 2])
      WSEL_A: wclk_d = ctl.play_fs;
      WSEL_B: wclk_d = ctl.rec_fs;
      WSEL_C: wclk_d = ctl.wclk_sec;
      default: wclk_d = 1'b0;
    endcase
    case (ctl.route[RT_SWCLK_LSB +: 2])
      WSEL_A: swclk_d = ctl.wclk_pin;
      WSEL_B: swclk_d = ctl.play_fs;
      WSEL_C: swclk_d = ctl.rec_fs;
      default: swclk_d = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl.bclk_out <= 1'b0;
      ctl.sbclk_out <= 1'b0;
      ctl.wclk_out <= 1'b0;
      ctl.swclk_out <= 1'b0;
      ctl.dout <= 1'b0;
      ctl.sdout <= 1'b0;
    end else begin
      ctl.bclk_out <= ctl.route[RT_BCLK_BIT] ? sbclk : ctl.bclk_gen;
      ctl.sbclk_out <= ctl.route[RT_SBCLK_BIT] ? ctl.bclk_gen
                                                : ctl.bclk_pin;
      ctl.wclk_out <= wclk_d;
      ctl.swclk_out <= swclk_d;
      ctl.dout <= ctl.route[RT_DOUT_BIT] ? ctl.din_sec : ctl.ser_out;
      ctl.sdout <= ctl.route[RT_SDOUT_BIT] ? ctl.ser_out : ctl.din_pin;
    end
  end
endmodule // apr_route
`default_nettype wire

// ===== design/apr_regs.sv
// Function
// - Bit 3 picks primary or secondary bit clock
// - Bit 2 picks primary or secondary word clock
// - Bit 1 picks record word clock source
// - Bit 0 picks primary or secondary data in
// - Bit clock pin: generated or secondary input
// - Secondary bit clock out: pin or generated
// - Word clock pin source code; 11 forbidden
// - Secondary word clock source code; 11 forbidden
// - Data-out pin: serial data or loopback
// - Secondary data out: loopback or serial data
// - General call accepted only when enabled
// - Record gain settled flags read live
// - Record converter power flags read live
// - AGC saturation flags sticky, cleared by read
// - Playback converter power flags read live
// - Line driver power flags read live
// - Headphone driver power flags read live
// - Playback gain settled flags read live
// - Secondary bit clock pin selected by code
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module apr_regs (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [apr_pkg::AW-1:0] I_ADDR,
  input wire logic [apr_pkg::DW-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [apr_pkg::DW-1:0] O_RDATA,
  input wire logic I_BCLK_PIN,
  input wire logic I_BCLK_GEN,
  input wire logic [3:0] I_SBCLK_PINS,
  input wire logic I_WCLK_PIN,
  input wire logic I_WCLK_SEC,
  input wire logic I_WCLK_REC_SEC,
  input wire logic I_PLAY_FS,
  input wire logic I_REC_FS,
  input wire logic I_DIN_PIN,
  input wire logic I_DIN_SEC,
  input wire logic I_SER_OUT,
  output logic O_BCLK_PORT,
  output logic O_WCLK_PORT,
  output logic O_WCLK_REC,
  output logic O_DIN_PORT,
  output logic O_BCLK_PIN,
  output logic O_SBCLK,
  output logic O_WCLK_PIN,
  output logic O_SWCLK,
  output logic O_DOUT,
  output logic O_SDOUT,
  output logic O_GENCALL_EN,
  input wire logic [1:0] I_REC_PGA_OK,
  input wire logic [1:0] I_REC_PWR,
  input wire logic [1:0] I_AGC_SAT,
  input wire logic [1:0] I_PLAY_PWR,
  input wire logic [1:0] I_LINE_PWR,
  input wire logic [1:0] I_HP_PWR,
  input wire logic [1:0] I_PLAY_PGA_OK
);
  import apr_pkg::*;
  // ==========================================================
  // Declarations
  // ==========================================================
  logic [3:0] src_q; // Source select, low nibble only
  logic [7:0] route_q; // Output routing
  logic gencall_q; // General call enable
  logic [1:0] sec_pin_q; // Secondary bit clock pin code
  logic [1:0] agc_q; // Sticky AGC flags, index 0 left
  logic [1:0] agc_clr; // Clear request from a read
  logic [DW-1:0] rdata_q; // Read data, one cycle after strobe
  logic [DW-1:0] rdata_d; // Read mux
  logic wr_src, wr_route, wr_misc, wr_pin; // Write decodes
  logic rd_rec; // Read of the record flag register
  apr_ctl_if ctl ();

  // ==========================================================
  // Write decode
  // ==========================================================
  // Only exact offsets write; all else is dropped
  always_comb begin
    wr_src = 1'b0;
    wr_route = 1'b0;
    wr_misc = 1'b0;
    wr_pin = 1'b0;
    if (I_WR && I_ADDR == ADDR_SRC) begin
      wr_src = 1'b1;
    end else if (I_WR && I_ADDR == ADDR_ROUTE) begin
      wr_route = 1'b1;
    end else if (I_WR && I_ADDR == ADDR_MISC) begin
      wr_misc = 1'b1;
    end else if (I_WR && I_ADDR == ADDR_SEC_PIN) begin
      wr_pin = 1'b1;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  // Source select; reserved upper nibble is not stored at all
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      src_q <= RST_SRC;
    end else if (wr_src) begin
      src_q <= I_WDATA[3:0];
    end
  end

  // Routing; reserved codes are stored, the router parks them
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      route_q <= RST_ROUTE;
    end else if (wr_route) begin
      route_q <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      gencall_q <= 1'b0;
    end else if (wr_misc) begin
      gencall_q <= I_WDATA[MISC_GC_BIT];
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      sec_pin_q <= RST_SEC_PIN;
    end else if (wr_pin) begin
      sec_pin_q <= I_WDATA[SEC_PIN_LSB +: 2];
    end
  end

  assign O_GENCALL_EN = gencall_q;

  // ==========================================================
  // Sticky AGC saturation flags
  // ==========================================================
  // clear on read of record flags
  assign rd_rec = I_RD && (I_ADDR == ADDR_REC);
  assign agc_clr = {2{rd_rec}};

  apr_sticky #(
    .W(2)
  ) u_agc (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_set(I_AGC_SAT),
    .i_clr(agc_clr),
    .o_flag(agc_q)
  );

  // ==========================================================
  // Read mux
  // ==========================================================
  // live flags sampled at the strobe
  always_comb begin
    rdata_d = '0;
    if (I_ADDR == ADDR_SRC) begin
      rdata_d = {4'h0, src_q};
    end else if (I_ADDR == ADDR_ROUTE) begin
      rdata_d = route_q;
    end else if (I_ADDR == ADDR_MISC) begin
      rdata_d[MISC_GC_BIT] = gencall_q;
    end else if (I_ADDR == ADDR_SEC_PIN) begin
      rdata_d[SEC_PIN_LSB +: 2] = sec_pin_q;
    end else if (I_ADDR == ADDR_REC) begin
      rdata_d = {I_REC_PGA_OK[0], I_REC_PWR[0], agc_q[0], 1'b0,
                 I_REC_PGA_OK[1], I_REC_PWR[1], agc_q[1], 1'b0};
    end else if (I_ADDR == ADDR_PLAY_PWR) begin
      rdata_d = {I_PLAY_PWR[0], I_LINE_PWR[0], I_HP_PWR[0], 1'b0,
                 I_PLAY_PWR[1], I_LINE_PWR[1], I_HP_PWR[1], 1'b0};
    end else if (I_ADDR == ADDR_PLAY_GAIN) begin
      rdata_d = {3'h0, I_PLAY_PGA_OK[0], 3'h0, I_PLAY_PGA_OK[1]};
    end
  end

  // Data stands one cycle only, zero otherwise, so stale
  // values never look like a fresh answer
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rdata_q <= '0;
    end else if (I_RD) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign O_RDATA = rdata_q;

  // ==========================================================
  // Router hookup
  // ==========================================================
  assign ctl.src = src_q;
  assign ctl.route = route_q;
  assign ctl.sec_pin = sec_pin_q;
  assign ctl.sbclk_pins = I_SBCLK_PINS;
  assign ctl.bclk_pin = I_BCLK_PIN;
  assign ctl.bclk_gen = I_BCLK_GEN;
  assign ctl.wclk_pin = I_WCLK_PIN;
  assign ctl.wclk_sec = I_WCLK_SEC;
  assign ctl.wclk_rsec = I_WCLK_REC_SEC;
  assign ctl.play_fs = I_PLAY_FS;
  assign ctl.rec_fs = I_REC_FS;
  assign ctl.din_pin = I_DIN_PIN;
  assign ctl.din_sec = I_DIN_SEC;
  assign ctl.ser_out = I_SER_OUT;

  // Muxes are flopped: one cycle latency on every routed net
  apr_route u_route (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .ctl(ctl.rtr)
  );

  assign O_BCLK_PORT = ctl.bclk_port;
  assign O_WCLK_PORT = ctl.wclk_port;
  assign O_WCLK_REC = ctl.wclk_rec;
  assign O_DIN_PORT = ctl.din_port;
  assign O_BCLK_PIN = ctl.bclk_out;
  assign O_SBCLK = ctl.sbclk_out;
  assign O_WCLK_PIN = ctl.wclk_out;
  assign O_SWCLK = ctl.swclk_out;
  assign O_DOUT = ctl.dout;
  assign O_SDOUT = ctl.sdout;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  logic sbclk_x; // Expected secondary bit clock
  assign sbclk_x = I_SBCLK_PINS[sec_pin_q];

  bclk_src_a: assert property (
    !$past(I_RST) |-> O_BCLK_PORT ==
      $past(src_q[SRC_BCLK_BIT] ? sbclk_x : I_BCLK_PIN))
    else $error("bit clock source wrong");

  wclk_src_a: assert property (
    !$past(I_RST) |-> O_WCLK_PORT ==
      $past(src_q[SRC_WCLK_BIT] ? I_WCLK_SEC : I_WCLK_PIN))
    else $error("word clock source wrong");

  rec_wclk_a: assert property (
    !$past(I_RST) |-> O_WCLK_REC ==
      $past(src_q[SRC_RECW_BIT] ? I_WCLK_REC_SEC : I_PLAY_FS))
    else $error("record word clock wrong");

  din_src_a: assert property (
    !$past(I_RST) |-> O_DIN_PORT ==
      $past(src_q[SRC_DIN_BIT] ? I_DIN_SEC : I_DIN_PIN))
    else $error("data in source wrong");

  bclk_pin_a: assert property (
    !$past(I_RST) |-> O_BCLK_PIN ==
      $past(route_q[RT_BCLK_BIT] ? sbclk_x : I_BCLK_GEN))
    else $error("bit clock pin wrong");

  sbclk_out_a: assert property (
    !$past(I_RST) |-> O_SBCLK ==
      $past(route_q[RT_SBCLK_BIT] ? I_BCLK_GEN : I_BCLK_PIN))
    else $error("secondary bit clock wrong");

  wclk_pin_a: assert property (
    (route_q[5:4] == WSEL_B) ##1 (route_q[5:4] == WSEL_B)
      |-> O_WCLK_PIN == $past(I_REC_FS))
    else $error("word clock pin wrong");

  swclk_out_a: assert property (
    (route_q[3:2] == WSEL_A) ##1 (route_q[3:2] == WSEL_A)
      |-> O_SWCLK == $past(I_WCLK_PIN))
    else $error("secondary word clock wrong");

  dout_pin_a: assert property (
    !$past(I_RST) |-> O_DOUT ==
      $past(route_q[RT_DOUT_BIT] ? I_DIN_SEC : I_SER_OUT))
    else $error("data out pin wrong");

  sdout_out_a: assert property (
    !$past(I_RST) |-> O_SDOUT ==
      $past(route_q[RT_SDOUT_BIT] ? I_SER_OUT : I_DIN_PIN))
    else $error("secondary data out wrong");

  gencall_wr_a: assert property (
    wr_misc |=> O_GENCALL_EN == $past(I_WDATA[MISC_GC_BIT]))
    else $error("general call enable wrong");

  rec_live_a: assert property (
    rd_rec |=> O_RDATA[7:6] == $past({I_REC_PGA_OK[0], I_REC_PWR[0]})
      && O_RDATA[3:2] == $past({I_REC_PGA_OK[1], I_REC_PWR[1]}))
    else $error("record flags wrong");

  agc_hold_a: assert property (
    I_AGC_SAT[0] |=> agc_q[0] until_with (rd_rec && !I_AGC_SAT[0]))
    else $error("agc flag lost");

  agc_clear_a: assert property (
    rd_rec && I_AGC_SAT == 2'h0 ##1 I_AGC_SAT == 2'h0
      |-> agc_q == 2'h0 ##1 O_RDATA[5] == 1'b0)
    else $error("agc flag not cleared");

  play_pwr_a: assert property (
    I_RD && I_ADDR == ADDR_PLAY_PWR |=> O_RDATA ==
      $past({I_PLAY_PWR[0], I_LINE_PWR[0], I_HP_PWR[0], 1'b0,
             I_PLAY_PWR[1], I_LINE_PWR[1], I_HP_PWR[1], 1'b0}))
    else $error("playback power flags wrong");

  play_gain_a: assert property (
    I_RD && I_ADDR == ADDR_PLAY_GAIN |=> O_RDATA ==
      $past({3'h0, I_PLAY_PGA_OK[0], 3'h0, I_PLAY_PGA_OK[1]}))
    else $error("playback gain flags wrong");

  ro_write_a: assert property (
    I_WR && I_ADDR == ADDR_SRC ##1 I_RD && I_ADDR == ADDR_SRC
      |=> O_RDATA == {4'h0, $past(I_WDATA[3:0], 2)})
    else $error("reserved bits stored");

  rd_quiet_a: assert property (
    !I_RD |=> O_RDATA == '0)
    else $error("read data outside its cycle");

  agc_rd_c: cover property (I_AGC_SAT[0] ##1 rd_rec ##1 O_RDATA[5]);
  gc_on_c: cover property (wr_misc && I_WDATA[MISC_GC_BIT]);
  loop_c: cover property (route_q[RT_DOUT_BIT] && !route_q[0]);
  sec_clk_c: cover property (src_q[SRC_BCLK_BIT] && sec_pin_q == 2'h3);
endmodule // apr_regs
`default_nettype wire

// ===== tb/apr_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module apr_regs_bench;
  import apr_pkg::*;
  // ==========================================================
  // Nets driven into and seen from the register bank
  // ==========================================================
  logic I_CLK_SYS, I_RST, I_WR, I_RD;
  logic [7:0] I_ADDR, I_WDATA, O_RDATA;
  logic I_BCLK_PIN, I_BCLK_GEN, I_WCLK_PIN, I_WCLK_SEC, I_WCLK_REC_SEC;
  logic I_PLAY_FS, I_REC_FS, I_DIN_PIN, I_DIN_SEC, I_SER_OUT;
  logic [3:0] I_SBCLK_PINS;
  logic [1:0] I_REC_PGA_OK, I_REC_PWR, I_AGC_SAT, I_PLAY_PWR, I_LINE_PWR;
  logic [1:0] I_HP_PWR, I_PLAY_PGA_OK;
  logic O_BCLK_PORT, O_WCLK_PORT, O_WCLK_REC, O_DIN_PORT, O_BCLK_PIN;
  logic O_SBCLK, O_WCLK_PIN, O_SWCLK, O_DOUT, O_SDOUT, O_GENCALL_EN;
  // All routed outputs in one vector, port selects on top
  wire [9:0] rout = {O_BCLK_PORT, O_WCLK_PORT, O_WCLK_REC, O_DIN_PORT,
    O_BCLK_PIN, O_SBCLK, O_WCLK_PIN, O_SWCLK, O_DOUT, O_SDOUT};
  // Shadow copies of the control fields, kept by the write task
  logic [3:0] src_m;
  logic [7:0] rt_m;
  logic [1:0] sp_m, agc_m;
  logic gc_m, run;
  logic [9:0] exp_q;
  logic [31:0] r, q;
  int skip, err_count, total_checks, seed, seed_m, i;
  // Every mapped place plus three unmapped ones
  logic [7:0] alist [11] = '{8'h00, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23,
    8'h24, 8'h25, 8'h26, 8'h80, 8'hFF};

  apr_regs dut (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_BCLK_PIN(I_BCLK_PIN), .I_BCLK_GEN(I_BCLK_GEN),
    .I_SBCLK_PINS(I_SBCLK_PINS), .I_WCLK_PIN(I_WCLK_PIN),
    .I_WCLK_SEC(I_WCLK_SEC), .I_WCLK_REC_SEC(I_WCLK_REC_SEC),
    .I_PLAY_FS(I_PLAY_FS), .I_REC_FS(I_REC_FS), .I_DIN_PIN(I_DIN_PIN),
    .I_DIN_SEC(I_DIN_SEC), .I_SER_OUT(I_SER_OUT),
    .O_BCLK_PORT(O_BCLK_PORT), .O_WCLK_PORT(O_WCLK_PORT),
    .O_WCLK_REC(O_WCLK_REC), .O_DIN_PORT(O_DIN_PORT),
    .O_BCLK_PIN(O_BCLK_PIN), .O_SBCLK(O_SBCLK), .O_WCLK_PIN(O_WCLK_PIN),
    .O_SWCLK(O_SWCLK), .O_DOUT(O_DOUT), .O_SDOUT(O_SDOUT),
    .O_GENCALL_EN(O_GENCALL_EN), .I_REC_PGA_OK(I_REC_PGA_OK),
    .I_REC_PWR(I_REC_PWR), .I_AGC_SAT(I_AGC_SAT), .I_PLAY_PWR(I_PLAY_PWR),
    .I_LINE_PWR(I_LINE_PWR), .I_HP_PWR(I_HP_PWR),
    .I_PLAY_PGA_OK(I_PLAY_PGA_OK)
  );

  // ==========================================================
  // Checking and closing
  // ==========================================================
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp,
    input string m);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t ns: %s seen %h expected %h", $time, m,
        seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Expectation functions
  // ==========================================================
  // Word clock code decode; code 11 must give a quiet output
  function automatic logic wsel(input logic [1:0] c, input logic a, b, d);
    case (c)
      2'h0: wsel = a;
      2'h1: wsel = b;
      2'h2: wsel = d;
      default: wsel = 1'b0;
    endcase
  endfunction

  // Routed values from the inputs as they stand right now
  function automatic logic [9:0] rexp();
    logic sb, wp;
    sb = I_SBCLK_PINS[sp_m];
    wp = src_m[2] ? I_WCLK_SEC : I_WCLK_PIN;
    rexp = {src_m[3] ? sb : I_BCLK_PIN, wp,
      src_m[1] ? I_WCLK_REC_SEC : I_PLAY_FS,
      src_m[0] ? I_DIN_SEC : I_DIN_PIN,
      rt_m[7] ? sb : I_BCLK_GEN, rt_m[6] ? I_BCLK_GEN : I_BCLK_PIN,
      wsel(rt_m[5:4], I_PLAY_FS, I_REC_FS, I_WCLK_SEC),
      wsel(rt_m[3:2], I_WCLK_PIN, I_PLAY_FS, I_REC_FS),
      rt_m[1] ? I_DIN_SEC : I_SER_OUT, rt_m[0] ? I_SER_OUT : I_DIN_PIN};
  endfunction

  // Read value of a place, status taken live at the read edge
  function automatic logic [7:0] rdexp(input logic [7:0] a);
    case (a)
      ADDR_SEC_PIN: rdexp = {1'b0, sp_m, 5'h00};
      ADDR_SRC: rdexp = {4'h0, src_m};
      ADDR_ROUTE: rdexp = rt_m;
      ADDR_MISC: rdexp = {2'h0, gc_m, 5'h00};
      ADDR_REC: rdexp = {I_REC_PGA_OK[0], I_REC_PWR[0], agc_m[0], 1'b0,
        I_REC_PGA_OK[1], I_REC_PWR[1], agc_m[1], 1'b0};
      ADDR_PLAY_PWR: rdexp = {I_PLAY_PWR[0], I_LINE_PWR[0], I_HP_PWR[0],
        1'b0, I_PLAY_PWR[1], I_LINE_PWR[1], I_HP_PWR[1], 1'b0};
      ADDR_PLAY_GAIN: rdexp = {3'h0, I_PLAY_PGA_OK[0], 3'h0,
        I_PLAY_PGA_OK[1]};
      default: rdexp = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Register bus tasks
  // ==========================================================
  // One write cycle, then an idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
    // Routed outputs may show old or new fields for one cycle
    skip = 1;
    case (a)
      ADDR_SEC_PIN: sp_m = d[6:5];
      ADDR_SRC: src_m = d[3:0];
      ADDR_ROUTE: rt_m = d;
      ADDR_MISC: gc_m = d[5];
      default: ;
    endcase
    @(posedge I_CLK_SYS);
  endtask

  // One read cycle; g pulses saturation at the read edge itself
  task automatic rd(input logic [7:0] a, input logic [1:0] g);
    logic [7:0] e, m;
    I_ADDR <= a;
    I_RD <= 1'b1;
    I_AGC_SAT <= g;
    @(posedge I_CLK_SYS);
    e = rdexp(a);
    // A set racing the clear leaves that read's value open
    m = (g != 2'h0) ? 8'hDD : 8'hFF;
    I_RD <= 1'b0;
    I_AGC_SAT <= 2'h0;
    @(negedge I_CLK_SYS);
    chk({2'h0, O_RDATA & m}, {2'h0, e & m}, "read data"); // readback
    @(negedge I_CLK_SYS);
    chk({2'h0, O_RDATA}, 10'h000, "read data after"); // quiet bus
    @(posedge I_CLK_SYS);
  endtask

  // ==========================================================
  // Clock, random pins and the bench model
  // ==========================================================
  always #2.5 I_CLK_SYS = ~I_CLK_SYS;

  // Pin and status levels change every cycle
  always @(posedge I_CLK_SYS) begin
    r = $random(seed);
    {I_BCLK_PIN, I_BCLK_GEN, I_SBCLK_PINS, I_WCLK_PIN, I_WCLK_SEC,
      I_WCLK_REC_SEC, I_PLAY_FS, I_REC_FS, I_DIN_PIN, I_DIN_SEC,
      I_SER_OUT} <= r[13:0];
    {I_REC_PGA_OK, I_REC_PWR, I_PLAY_PWR, I_LINE_PWR, I_HP_PWR,
      I_PLAY_PGA_OK} <= r[25:14];
  end

  // One cycle of latency on every routed path
  always @(posedge I_CLK_SYS) begin
    exp_q <= rexp();
  end

  // Saturation flags: set wins over the clear by a read
  always @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      agc_m <= 2'h0;
    end else begin
      agc_m <= ((I_RD && I_ADDR == ADDR_REC) ? 2'h0 : agc_m) | I_AGC_SAT;
    end
  end

  // Routed outputs compared at mid-cycle, where they are settled
  always @(negedge I_CLK_SYS) begin
    if (run && !I_RST) begin
      if (skip > 0) begin
        skip--;
      end else begin
        chk({6'h00, rout[9:6]}, {6'h00, exp_q[9:6]}, "port selects"); // port selects
        chk({4'h0, rout[5:0]}, {4'h0, exp_q[5:0]}, "pin routing"); // pin routing
        chk({9'h000, O_GENCALL_EN}, {9'h000, gc_m}, "general call"); // enable level
      end
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    I_CLK_SYS = 1'b0;
    I_RST = 1'b1;
    {I_WR, I_RD, I_ADDR, I_WDATA, I_AGC_SAT} = '0;
    {I_BCLK_PIN, I_BCLK_GEN, I_SBCLK_PINS, I_WCLK_PIN, I_WCLK_SEC,
      I_WCLK_REC_SEC, I_PLAY_FS, I_REC_FS, I_DIN_PIN, I_DIN_SEC,
      I_SER_OUT} = '0;
    {I_REC_PGA_OK, I_REC_PWR, I_PLAY_PWR, I_LINE_PWR, I_HP_PWR,
      I_PLAY_PGA_OK} = '0;
    {src_m, rt_m, sp_m, gc_m, run} = '0;
    seed = 32'h2b2babdf;
    seed_m = 32'h2b2babdf;
    {skip, err_count, total_checks} = '0;
    repeat (20) @(posedge I_CLK_SYS);
    chk(rout, 10'h000, "outputs in reset");
    I_RST <= 1'b0;
    repeat (2) @(posedge I_CLK_SYS);
    run = 1'b1;
    // Reset values, then all ones written everywhere
    for (i = 0; i < 11; i++) rd(alist[i], 2'h0);
    for (i = 0; i < 11; i++) wr(alist[i], 8'hFF);
    for (i = 0; i < 11; i++) rd(alist[i], 2'h0);
    wr(ADDR_MISC, 8'h00);
    // Saturation pulse, sticky until read, then a racing set
    I_AGC_SAT <= 2'h1;
    @(posedge I_CLK_SYS);
    I_AGC_SAT <= 2'h0;
    repeat (3) @(posedge I_CLK_SYS);
    rd(ADDR_REC, 2'h0);
    rd(ADDR_REC, 2'h0);
    rd(ADDR_REC, 2'h2);
    rd(ADDR_REC, 2'h0);
    // Random settings; word clock codes walk through all pairs
    for (i = 0; i < 48; i++) begin
      q = $random(seed_m);
      wr(ADDR_SRC, q[7:0]);
      wr(ADDR_ROUTE, {q[15:14], i[1:0], i[3:2], q[9:8]});
      wr(ADDR_SEC_PIN, q[23:16]);
      wr(ADDR_MISC, q[31:24]);
      // Write then read with no gap between the strobes
      I_ADDR <= ADDR_SRC;
      I_WDATA <= q[31:24];
      I_WR <= 1'b1;
      @(posedge I_CLK_SYS);
      I_WR <= 1'b0;
      src_m = q[27:24];
      skip = 1;
      rd(ADDR_SRC, 2'h0);
      repeat (3) @(posedge I_CLK_SYS);
      rd(alist[i % 11], 2'h0);
    end
    // Second reset in mid-run clears every field again
    run = 1'b0;
    I_RST <= 1'b1;
    repeat (3) @(posedge I_CLK_SYS);
    {src_m, rt_m, sp_m, gc_m} = '0;
    I_RST <= 1'b0;
    repeat (2) @(posedge I_CLK_SYS);
    run = 1'b1;
    for (i = 0; i < 11; i++) rd(alist[i], 2'h0);
    end_of_test();
  end

  // Watchdog far beyond the thousand or so cycles the run needs
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule // apr_regs_bench
`default_nettype wire
